/* verilog/drive_seq_pkg.sv */
package drive_seq_pkg;

    // main state codes
    typedef enum logic [2:0] {
        ST_BLOCKED  = 3'h0,
        ST_ALLOWED  = 3'h1,
        ST_POWERED  = 3'h2,
        ST_READY    = 3'h3,
        ST_ENABLED  = 3'h4,
        ST_QHALT    = 3'h5,
        ST_FAULTING = 3'h6,
        ST_LATCHED  = 3'h7
    } main_state_t;

    // pin vector positions
    localparam int PIN_W    = 5;
    localparam int PIN_RUN  = 0;
    localparam int PIN_JOG  = 1;
    localparam int PIN_QH_N = 2;
    localparam int PIN_FH_N = 3;
    localparam int PIN_FLT  = 4;

    // status output vector positions
    localparam int OUT_W       = 9;
    localparam int OUT_RUNNING = 0;
    localparam int OUT_JOGGING = 1;
    localparam int OUT_STOP    = 2;
    localparam int OUT_FAULT   = 3;
    localparam int OUT_SWITCH  = 4;
    localparam int OUT_PERMIT  = 5;
    localparam int OUT_POWERED = 6;
    localparam int OUT_READY   = 7;
    localparam int OUT_NOFAULT = 8;
    localparam logic [OUT_W-1:0] OUT_RESET = 9'h100;

    // register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_STATE  = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_MASK   = 5'h08;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_CMD    = 5'h10;

    // state word field positions
    localparam int STATE_OUT_LSB = 8;
    localparam int STATE_PIN_LSB = 24;

    // control word: bit0 remote select, bits 1..4 remote pins
    localparam int CTRL_W = 5;
    localparam int CTRL_REMOTE = 0;
    localparam int CTRL_PIN_LSB = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h18;

    // interrupt events
    localparam int EV_W       = 3;
    localparam int EV_CHANGE  = 0;
    localparam int EV_FAULT   = 1;
    localparam int EV_HALTRET = 2;
    localparam int CMD_RESTORE = 0;

endpackage

/* verilog/drive_main_sequencer_fsm.sv */
// Overview of operation
// - main state reported as codes 0..7
// - code 0 ignores run/jog; code 1 accepts
// - power-up or config events force code 0
// - fault rise in codes 0/1 enters 6
// - 0 to 1 when idle and halts released
// - 1 to 0 when either halt drops
// - 1 to 2 on run or jog
// - fault exit wins on overlap, then halt drop, then run/jog
// - fault in 6/7; running in 4 only
// - permit 1..6; powered 2..6 only
// - ready 3..6; no-fault 0..5 not 6
// - switch true 2..6, false 7, else held
// - jogging only during jog cycle in 4
// - stopping in stop cycle in 4 or code 5
// - code 7 no-fault once run/jog false
`timescale 1ns/1ps
`default_nettype none

module drive_main_sequencer_fsm
    import drive_seq_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // terminal pins
    input  wire logic              run,
    input  wire logic              jog,
    input  wire logic              quick_halt_n,
    input  wire logic              freewheel_halt_n,
    input  wire logic              fault,
    // configuration events
    input  wire logic              cfg_restore,
    input  wire logic              cfg_exit,
    // companion sequencing logic
    input  wire logic              ext_next_valid,
    input  wire logic [2:0]        ext_next_state,
    input  wire logic              jog_cycle,
    input  wire logic              stop_cycle,
    // status outputs
    output logic [2:0]             main_state_code,
    output logic                   running,
    output logic                   jogging,
    output logic                   stopping,
    output logic                   fault_status,
    output logic                   output_switch,
    output logic                   power_on_permit,
    output logic                   power_applied,
    output logic                   ready,
    output logic                   no_fault,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // interrupt
    output logic                   irq
);

    // ------------------------------------------------
    // state
    // ------------------------------------------------
    typedef struct packed {
        logic [PIN_W-1:0]  sync1;
        logic [PIN_W-1:0]  sync2;
        logic [PIN_W-1:0]  sync3;
        logic [PIN_W-1:0]  filt;
        logic              fault_prev;
        main_state_t       state;
        logic              healthy7;
        logic [OUT_W-1:0]  outs;
        logic              ack;
        logic [31:0]       rdata;
        logic [CTRL_W-1:0] ctrl;
        logic [EV_W-1:0]   mask;
        logic [EV_W-1:0]   status;
        logic              cfg_req;
    } regs_t;

    regs_t q;
    regs_t d;

    // ------------------------------------------------
    // decode helpers
    // ------------------------------------------------
    function automatic logic in_range(
        input main_state_t s,
        input main_state_t lo,
        input main_state_t hi);
        in_range = (s >= lo) && (s <= hi);
    endfunction

    function automatic logic addr_is(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] r);
        addr_is = (a == r);
    endfunction

    // ------------------------------------------------
    // input selection
    // ------------------------------------------------
    logic             remote;
    logic [PIN_W-1:0] pins;
    logic             run_e;
    logic             jog_e;
    logic             qh_n_e;
    logic             fh_n_e;
    logic             fault_rise;
    logic             cfg_evt;
    logic             bus_req;
    logic             bus_wr;

    assign pins = {fault, freewheel_halt_n, quick_halt_n, jog, run};
    assign remote = q.ctrl[CTRL_REMOTE];
    assign run_e = remote ? q.ctrl[CTRL_PIN_LSB+PIN_RUN] : q.filt[PIN_RUN];
    assign jog_e = remote ? q.ctrl[CTRL_PIN_LSB+PIN_JOG] : q.filt[PIN_JOG];
    assign qh_n_e = remote ? q.ctrl[CTRL_PIN_LSB+PIN_QH_N] : q.filt[PIN_QH_N];
    assign fh_n_e = remote ? q.ctrl[CTRL_PIN_LSB+PIN_FH_N] : q.filt[PIN_FH_N];
    // fault stays a terminal-only input so a remote source cannot mask it
    assign fault_rise = q.filt[PIN_FLT] & ~q.fault_prev;
    assign cfg_evt = cfg_restore | cfg_exit | q.cfg_req;
    assign bus_req = avs_read | avs_write;
    assign bus_wr = avs_write & q.ack & avs_byteenable[0];

    // ------------------------------------------------
    // next state
    // ------------------------------------------------
    always_comb begin
        d = q;

        // three-stage sync; a change counts once stages two and three agree
        d.sync1 = pins;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < PIN_W; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                d.filt[i] = q.sync3[i];
            end
        end
        d.fault_prev = q.filt[PIN_FLT];

        // main sequencing
        if (cfg_evt) begin
            d.state = ST_BLOCKED;
        end else begin
            unique case (q.state)
                ST_BLOCKED: begin
                    // run/jog alone never leave this state
                    if (fault_rise) begin
                        d.state = ST_FAULTING;
                    end else if (!run_e && !jog_e && qh_n_e && fh_n_e) begin
                        d.state = ST_ALLOWED;
                    end
                end
                ST_ALLOWED: begin
                    if (fault_rise) begin
                        d.state = ST_FAULTING;
                    end else if (!fh_n_e || !qh_n_e) begin
                        d.state = ST_BLOCKED;
                    end else if (run_e || jog_e) begin
                        d.state = ST_POWERED;
                    end
                end
                ST_POWERED, ST_READY, ST_ENABLED,
                ST_QHALT, ST_FAULTING, ST_LATCHED: begin
                    if (ext_next_valid) begin
                        d.state = main_state_t'(ext_next_state);
                    end
                end
            endcase
        end

        // no-fault recovery while latched
        if (d.state != ST_LATCHED || q.state != ST_LATCHED) begin
            d.healthy7 = 1'b0;
        end else if (!run_e && !jog_e) begin
            d.healthy7 = 1'b1;
        end

        // status outputs follow the new state in the same edge
        d.outs[OUT_RUNNING] = (d.state == ST_ENABLED);
        d.outs[OUT_JOGGING] = (d.state == ST_ENABLED) && jog_cycle;
        d.outs[OUT_STOP] = ((d.state == ST_ENABLED) && stop_cycle)
                         || (d.state == ST_QHALT);
        d.outs[OUT_FAULT] = in_range(d.state, ST_FAULTING, ST_LATCHED);
        d.outs[OUT_PERMIT] = in_range(d.state, ST_ALLOWED, ST_FAULTING);
        d.outs[OUT_POWERED] = in_range(d.state, ST_POWERED, ST_FAULTING);
        d.outs[OUT_READY] = in_range(d.state, ST_READY, ST_FAULTING);
        d.outs[OUT_NOFAULT] = in_range(d.state, ST_BLOCKED, ST_QHALT)
                            || ((d.state == ST_LATCHED) && d.healthy7);
        if (in_range(d.state, ST_POWERED, ST_FAULTING)) begin
            d.outs[OUT_SWITCH] = 1'b1;
        end else if (d.state == ST_LATCHED) begin
            d.outs[OUT_SWITCH] = 1'b0;
        end

        // bus: one wait cycle, then answer
        d.ack = bus_req & ~q.ack;
        d.cfg_req = 1'b0;
        if (avs_read && !q.ack) begin
            d.rdata = 32'h0000_0000;
            if (addr_is(avs_address, REG_STATE)) begin
                d.rdata[2:0] = q.state;
                d.rdata[STATE_OUT_LSB +: OUT_W] = q.outs;
                d.rdata[STATE_PIN_LSB +: PIN_W] = q.filt;
            end else if (addr_is(avs_address, REG_STATUS)) begin
                d.rdata[EV_W-1:0] = q.status;
            end else if (addr_is(avs_address, REG_MASK)) begin
                d.rdata[EV_W-1:0] = q.mask;
            end else if (addr_is(avs_address, REG_CTRL)) begin
                d.rdata[CTRL_W-1:0] = q.ctrl;
            end
        end
        if (bus_wr && addr_is(avs_address, REG_MASK)) begin
            d.mask = avs_writedata[EV_W-1:0];
        end
        if (bus_wr && addr_is(avs_address, REG_CTRL)) begin
            d.ctrl = avs_writedata[CTRL_W-1:0];
        end
        if (bus_wr && addr_is(avs_address, REG_CMD)) begin
            d.cfg_req = avs_writedata[CMD_RESTORE];
        end

        // sticky events; a set in the clearing cycle wins
        if (bus_wr && addr_is(avs_address, REG_STATUS)) begin
            d.status = q.status & ~avs_writedata[EV_W-1:0];
        end
        d.status[EV_CHANGE] = d.status[EV_CHANGE] | (d.state != q.state);
        d.status[EV_FAULT] = d.status[EV_FAULT]
                           | ((d.state == ST_FAULTING) && (q.state != ST_FAULTING));
        d.status[EV_HALTRET] = d.status[EV_HALTRET]
                             | ((q.state == ST_ALLOWED) && (d.state == ST_BLOCKED));
    end

    // ------------------------------------------------
    // registers
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q.sync1 <= '0;
            q.sync2 <= '0;
            q.sync3 <= '0;
            q.filt <= '0;
            q.fault_prev <= 1'b0;
            q.state <= ST_BLOCKED;
            q.healthy7 <= 1'b0;
            q.outs <= OUT_RESET;
            q.ack <= 1'b0;
            q.rdata <= 32'h0000_0000;
            q.ctrl <= CTRL_RESET;
            q.mask <= '0;
            q.status <= '0;
            q.cfg_req <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    assign main_state_code = q.state;
    assign running = q.outs[OUT_RUNNING];
    assign jogging = q.outs[OUT_JOGGING];
    assign stopping = q.outs[OUT_STOP];
    assign fault_status = q.outs[OUT_FAULT];
    assign output_switch = q.outs[OUT_SWITCH];
    assign power_on_permit = q.outs[OUT_PERMIT];
    assign power_applied = q.outs[OUT_POWERED];
    assign ready = q.outs[OUT_READY];
    assign no_fault = q.outs[OUT_NOFAULT];
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = bus_req & ~q.ack;
    assign irq = |(q.status & q.mask);

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reset_to_blocked_a: assert property (
        @(posedge clk) disable iff (1'b0)
        rst |=> (main_state_code == ST_BLOCKED))
        else $error("reset did not enter blocked");

    blocked_ignore_a: assert property (
        (q.state == ST_BLOCKED) && !cfg_evt && !fault_rise
        && (run_e || jog_e) |=> (q.state == ST_BLOCKED))
        else $error("run left blocked state");

    fault_entry_a: assert property (
        in_range(q.state, ST_BLOCKED, ST_ALLOWED) && fault_rise && !cfg_evt
        |=> (q.state == ST_FAULTING) && fault_status && !no_fault)
        else $error("fault rise not taken");

    allow_entry_a: assert property (
        (q.state == ST_BLOCKED) && !cfg_evt && !fault_rise && !run_e
        && !jog_e && qh_n_e && fh_n_e |=> (q.state == ST_ALLOWED) && power_on_permit)
        else $error("idle blocked did not allow");

    halt_return_a: assert property (
        (q.state == ST_ALLOWED) && !cfg_evt && !fault_rise && (!qh_n_e || !fh_n_e)
        |=> (q.state == ST_BLOCKED) && q.status[EV_HALTRET])
        else $error("halt drop did not block");

    run_apply_a: assert property (
        (q.state == ST_ALLOWED) && !cfg_evt && !fault_rise && qh_n_e
        && fh_n_e && (run_e || jog_e) |=> (q.state == ST_POWERED) && power_applied)
        else $error("run did not power");

    exit_priority_a: assert property (
        (q.state == ST_ALLOWED) && !cfg_evt && fault_rise && !qh_n_e
        |=> (q.state == ST_FAULTING))
        else $error("halt beat fault");

    fault_running_a: assert property (
        (fault_status == in_range(q.state, ST_FAULTING, ST_LATCHED))
        && (running == (q.state == ST_ENABLED)))
        else $error("fault or running mismatch");

    permit_power_a: assert property (
        (power_on_permit == in_range(q.state, ST_ALLOWED, ST_FAULTING))
        && (power_applied == in_range(q.state, ST_POWERED, ST_FAULTING)))
        else $error("permit or powered mismatch");

    ready_health_a: assert property (
        (ready == in_range(q.state, ST_READY, ST_FAULTING))
        && (!in_range(q.state, ST_BLOCKED, ST_QHALT) || no_fault)
        && ((q.state != ST_FAULTING) || !no_fault))
        else $error("ready or no-fault mismatch");

    switch_hold_a: assert property (
        in_range(q.state, ST_BLOCKED, ST_ALLOWED)
        && in_range($past(q.state), ST_BLOCKED, ST_ALLOWED) |-> $stable(output_switch))
        else $error("switch changed in low states");

    switch_level_a: assert property (
        (!in_range(q.state, ST_POWERED, ST_FAULTING) || output_switch)
        && ((q.state != ST_LATCHED) || !output_switch))
        else $error("switch level wrong");

    jog_stop_a: assert property (
        (!jogging || (q.state == ST_ENABLED))
        && ((q.state != ST_QHALT) || stopping))
        else $error("jogging or stopping wrong");

    latched_recover_a: assert property (
        (q.state == ST_LATCHED) ##1 (q.state == ST_LATCHED && $past(!run_e && !jog_e))
        |-> no_fault)
        else $error("latched no-fault not restored");

    companion_next_a: assert property (
        in_range(q.state, ST_POWERED, ST_LATCHED) && ext_next_valid && !cfg_evt
        |=> (main_state_code == $past(ext_next_state)))
        else $error("companion state not taken");

    bus_answer_a: assert property (
        bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    allow_cover_c: cover property ((q.state == ST_BLOCKED) ##1 (q.state == ST_ALLOWED));
    run_cover_c: cover property ((q.state == ST_ALLOWED) ##1 (q.state == ST_POWERED));
    fault_cover_c: cover property ((q.state == ST_ALLOWED) ##1 (q.state == ST_FAULTING));
    irq_cover_c: cover property ($rose(irq));

endmodule

`default_nettype wire

/* tb/cmd_source.sv */
`timescale 1ns/1ps
`default_nettype none

module cmd_source
    import drive_seq_pkg::*;
(
    // bench side
    input  wire logic             clk,
    input  wire logic             slow,
    input  wire logic [PIN_W-1:0] cmd,
    // terminal pins
    output logic                  run,
    output logic                  jog,
    output logic                  quick_halt_n,
    output logic                  freewheel_halt_n,
    output logic                  fault
);
    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // halts idle released, so power-up is not a stop demand
    logic [PIN_W-1:0] lag_q = 5'h0C;
    logic [PIN_W-1:0] pin_q = 5'h0C;

    // slow mode lags one cycle, like a source behind a link
    always @(posedge clk) begin
        lag_q <= cmd;
        pin_q <= slow ? lag_q : cmd;
    end

    assign run              = pin_q[PIN_RUN];
    assign jog              = pin_q[PIN_JOG];
    assign quick_halt_n     = pin_q[PIN_QH_N];
    assign freewheel_halt_n = pin_q[PIN_FH_N];
    assign fault            = pin_q[PIN_FLT];
endmodule

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import drive_seq_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic              clk, rst, slow, cfg_restore, cfg_exit;
    logic              ext_next_valid, jog_cycle, stop_cycle;
    logic [2:0]        ext_next_state, main_state_code;
    logic [PIN_W-1:0]  cmd;
    logic              running, jogging, stopping, fault_status, output_switch;
    logic              power_on_permit, power_applied, ready, no_fault, irq;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read, avs_write, avs_waitrequest;
    logic [31:0]       avs_writedata, avs_readdata;
    logic [3:0]        avs_byteenable;
    wire               run, jog, quick_halt_n, freewheel_halt_n, fault;
    logic [11:0]       exp_q[$];
    logic [31:0]       rd_q[$];
    logic [11:0]       prev_v;
    logic [7:0]        seed;
    int                failures, n_tests;
    wire  [11:0]       cur_v = {main_state_code, no_fault, ready, power_applied, power_on_permit,
                                output_switch, fault_status, stopping, jogging, running};

    cmd_source i_src (.clk(clk), .slow(slow), .cmd(cmd), .run(run), .jog(jog),
        .quick_halt_n(quick_halt_n), .freewheel_halt_n(freewheel_halt_n), .fault(fault));

    drive_main_sequencer_fsm i_dut (.clk(clk), .rst(rst), .run(run), .jog(jog),
        .quick_halt_n(quick_halt_n), .freewheel_halt_n(freewheel_halt_n), .fault(fault),
        .cfg_restore(cfg_restore), .cfg_exit(cfg_exit), .ext_next_valid(ext_next_valid),
        .ext_next_state(ext_next_state), .jog_cycle(jog_cycle), .stop_cycle(stop_cycle),
        .main_state_code(main_state_code), .running(running), .jogging(jogging),
        .stopping(stopping), .fault_status(fault_status), .output_switch(output_switch),
        .power_on_permit(power_on_permit), .power_applied(power_applied), .ready(ready),
        .no_fault(no_fault), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

    always #2 clk = ~clk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic logic [OUT_W-1:0] outs(input logic [2:0] s, input logic sw, nf, jg, sp);
        outs = '0;
        outs[OUT_RUNNING] = (s == 3'h4);
        outs[OUT_JOGGING] = jg;
        outs[OUT_STOP]    = sp;
        outs[OUT_FAULT]   = (s >= 3'h6);
        outs[OUT_SWITCH]  = sw;
        outs[OUT_PERMIT]  = (s >= 3'h1) && (s <= 3'h6);
        outs[OUT_POWERED] = (s >= 3'h2) && (s <= 3'h6);
        outs[OUT_READY]   = (s >= 3'h3) && (s <= 3'h6);
        outs[OUT_NOFAULT] = (s <= 3'h5) || (s == 3'h7 && nf);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("mismatches %0d of %0d compares", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic push(input logic [2:0] s, input logic sw, input logic nf = 0,
                        input logic jg = 0, input logic sp = 0);
        exp_q.push_back({s, outs(s, sw, nf, jg, sp)});
    endtask

    // wait until every noted change was seen, then idle so strays show up
    task automatic wq;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) chk(32'h0, 32'h1);
        repeat (8) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n == 50) chk(32'h0, 32'h1);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic go_ext(input logic [2:0] s);
        ext_next_state <= s;
        ext_next_valid <= 1'b1;
        @(posedge clk);
        ext_next_valid <= 1'b0;
        wq;
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst && cur_v !== prev_v) begin
            if (exp_q.size() == 0) chk(32'(cur_v), 32'(prev_v));
            else chk(32'(cur_v), 32'(exp_q.pop_front()));
        end
        if (avs_read && avs_waitrequest === 1'b0) chk(avs_readdata, rd_q.pop_front());
        prev_v <= cur_v;
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 0; rst = 1; slow = 0; cmd = 5'h0C; cfg_restore = 0; cfg_exit = 0;
        ext_next_valid = 0; ext_next_state = 3'h0; jog_cycle = 0; stop_cycle = 0;
        avs_address = '0; avs_read = 0; avs_write = 0; avs_writedata = '0;
        avs_byteenable = 4'hF; failures = 0; n_tests = 0; seed = 8'h32;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(cur_v), 32'({3'h0, OUT_RESET}));
        push(3'h1, 1'b0);
        rd(REG_CTRL, 32'h18);
        wr(5'h14, 32'hFFFF_FFFF);
        rd(5'h14, 32'h0);
        seed = lfsr(seed);
        wr(REG_MASK, 32'(seed[2:0]));
        avs_byteenable <= 4'h0;
        wr(REG_MASK, 32'h7);
        avs_byteenable <= 4'hF;
        rd(REG_MASK, 32'(seed[2:0]));
        wq;
        wr(REG_STATE, 32'h7);
        rd(REG_STATE, {3'h0, 5'h0C, 7'h0, outs(3'h1, 0, 0, 0, 0), 5'h0, 3'h1});
        // halt drop leaves the allowed state and flags an event
        cmd <= 5'h08;
        push(3'h0, 1'b0);
        wq;
        rd(REG_STATUS, 32'h5);
        wr(REG_MASK, 32'h4);
        chk(32'(irq), 32'h1);
        wr(REG_STATUS, 32'h5);
        chk(32'(irq), 32'h0);
        rd(REG_STATUS, 32'h0);
        // run while blocked is ignored, also once halts release
        slow <= 1'b1;
        cmd <= 5'h09;
        wq;
        cmd <= 5'h0D;
        wq;
        cmd <= 5'h0C;
        slow <= 1'b0;
        push(3'h1, 1'b0);
        wq;
        seed = lfsr(seed);
        cmd <= 5'h0C | (seed[0] ? 5'h02 : 5'h01);
        push(3'h2, 1'b1);
        wq;
        push(3'h7, 1'b0, 1'b0);
        go_ext(3'h7);
        cmd <= 5'h0C;
        push(3'h7, 1'b0, 1'b1);
        wq;
        push(3'h4, 1'b1);
        go_ext(3'h4);
        jog_cycle <= 1'b1;
        push(3'h4, 1'b1, 0, 1'b1);
        wq;
        jog_cycle <= 1'b0;
        stop_cycle <= 1'b1;
        push(3'h4, 1'b1, 0, 1'b0, 1'b1);
        wq;
        stop_cycle <= 1'b0;
        push(3'h4, 1'b1);
        wq;
        push(3'h5, 1'b1, 0, 0, 1'b1);
        go_ext(3'h5);
        jog_cycle <= 1'b1;
        push(3'h6, 1'b1);
        go_ext(3'h6);
        jog_cycle <= 1'b0;
        push(3'h0, 1'b1);
        push(3'h1, 1'b1);
        go_ext(3'h0);
        // fault, halt drop and run together: fault wins
        cmd <= 5'h11;
        push(3'h6, 1'b1);
        wq;
        push(3'h0, 1'b1);
        go_ext(3'h0);
        cmd <= 5'h1C;
        push(3'h1, 1'b1);
        wq;
        cmd <= 5'h08;
        push(3'h0, 1'b1);
        wq;
        wr(REG_STATUS, 32'h7);
        rd(REG_STATUS, 32'h0);
        cmd <= 5'h1C;
        push(3'h6, 1'b1);
        wq;
        rd(REG_STATUS, 32'h3);
        push(3'h0, 1'b1);
        push(3'h1, 1'b1);
        go_ext(3'h0);
        cmd <= 5'h0C;
        for (int k = 0; k < 3; k++) begin
            push(3'h0, 1'b1);
            push(3'h1, 1'b1);
            if (k == 2) wr(REG_CMD, 32'h1);
            else begin
                cfg_restore <= (k == 0);
                cfg_exit    <= (k == 1);
                @(posedge clk);
                cfg_restore <= 1'b0;
                cfg_exit    <= 1'b0;
            end
            wq;
        end
        // remote source overrides the blocked pins
        cmd <= 5'h08;
        push(3'h0, 1'b1);
        wq;
        push(3'h1, 1'b1);
        wr(REG_CTRL, 32'h19);
        wq;
        push(3'h2, 1'b1);
        wr(REG_CTRL, 32'h1B);
        wq;
        push(3'h0, 1'b1);
        go_ext(3'h0);
        wr(REG_CTRL, 32'h18);
        wq;
        report_and_stop;
    end
endmodule

`default_nettype wire
